// *** hdl/twhf_status_mux.sv ***
// Status byte composer for the channel-3 window status register
`timescale 1ns/100ps
`default_nettype none

module twhf_status_mux (
  // Layout settings
  input wire logic window_enable,
  input wire logic status_layout_select,
  // Window flags
  input wire logic window_in_full,
  input wire logic window_out_full,
  input wire logic host_write_mode_flag,
  input wire logic local_write_mode_flag,
  input wire logic out_full_flag,
  // Bits owned by neighbouring logic
  input wire logic [2:0] shared_low_bits,
  input wire logic [7:0] plain_status,
  // Composed status
  output logic window_layout,
  output logic [7:0] status_byte
);

  // ---------------------------------------------------------------
  // Layout choice
  // ---------------------------------------------------------------
  assign window_layout = window_enable | ~status_layout_select;

  always_comb begin
    if (window_layout) begin
      status_byte = 8'h00;
      status_byte[twhf_pkg::BIT_IN_FULL] = window_in_full;
      status_byte[twhf_pkg::BIT_OUT_FULL] = window_out_full;
      status_byte[twhf_pkg::BIT_HOST_WM] = host_write_mode_flag;
      status_byte[twhf_pkg::BIT_LOCAL_WM] = local_write_mode_flag;
      status_byte[twhf_pkg::BIT_LOW_TOP:twhf_pkg::BIT_LOW_BOT] =
        shared_low_bits;
      status_byte[twhf_pkg::BIT_ODR_FULL] = out_full_flag;
    end else begin
      // Plain layout belongs entirely to neighbouring logic
      status_byte = plain_status;
    end
  end

endmodule : twhf_status_mux

`default_nettype wire

// *** hdl/twhf_flags.sv ***
// Package and top module of the two-way window handshake flags
//
// Functional notes
// - Window status layout shown when window enabled or layout select is 0.
// - Host write to last window register sets input-full, status bit 7.
// - Input-full flag is an interrupt source toward the local processor.
// - Local read of last window register clears input-full.
// - Local write to last window register sets output-full, status bit 6.
// - Output-full cleared by host read of last register or local write 0.
// - Local writes to output-full flags: 0 clears, 1 leaves unchanged.
// - Host write to first window register sets host mode bit 5 if local clear.
// - Local read of last window register clears host write-mode flag.
// - Local write of output data register sets its output-full flag.
// - Local write of first register sets local mode if host clear; host wins.
// - Local mode cleared by host read of last register or local write 0.

package twhf_pkg;

  // ---------------------------------------------------------------
  // Status bit positions, window layout
  // ---------------------------------------------------------------
  localparam int BIT_IN_FULL = 7;
  localparam int BIT_OUT_FULL = 6;
  localparam int BIT_HOST_WM = 5;
  localparam int BIT_LOCAL_WM = 4;
  localparam int BIT_LOW_TOP = 3;
  localparam int BIT_LOW_BOT = 1;
  localparam int BIT_ODR_FULL = 0;

  // ---------------------------------------------------------------
  // Status bits cleared by a local write of 0
  // ---------------------------------------------------------------
  localparam int N_WCLR = 3;
  localparam int WCLR_OUT = 0;
  localparam int WCLR_LOCAL = 1;
  localparam int WCLR_ODR = 2;
  localparam int WCLR_BIT [N_WCLR] = '{
    BIT_OUT_FULL,
    BIT_LOCAL_WM,
    BIT_ODR_FULL
  };

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic RST_FLAG = 1'b0;
  localparam logic [7:0] RST_ODR = 8'h00;

  typedef struct packed {
    logic window_in_full;
    logic window_out_full;
    logic host_write_mode_flag;
    logic local_write_mode_flag;
    logic out_full_flag;
    logic [7:0] out_data_reg;
  } twhf_state_t;

  localparam twhf_state_t RST_STATE = '{
    window_in_full: RST_FLAG,
    window_out_full: RST_FLAG,
    host_write_mode_flag: RST_FLAG,
    local_write_mode_flag: RST_FLAG,
    out_full_flag: RST_FLAG,
    out_data_reg: RST_ODR
  };

endpackage : twhf_pkg

`timescale 1ns/100ps
`default_nettype none

module twhf_flags (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Layout settings
  input wire logic window_enable,
  input wire logic status_layout_select,
  // Host I/O cycles, decoded one-cycle pulses
  input wire logic host_wr_last,
  input wire logic host_rd_last,
  input wire logic host_wr_first,
  input wire logic host_rd_odr,
  // Local processor accesses, one-cycle pulses
  input wire logic local_wr_last,
  input wire logic local_rd_last,
  input wire logic local_wr_first,
  input wire logic local_wr_odr,
  input wire logic local_wr_status,
  input wire logic [7:0] local_wr_data,
  // Bits owned by neighbouring logic
  input wire logic [2:0] shared_low_bits,
  input wire logic [7:0] plain_status,
  // Results
  output logic window_in_full_irq,
  output logic [7:0] out_data,
  output logic [7:0] channel3_window_status
);

  twhf_pkg::twhf_state_t s_q;
  twhf_pkg::twhf_state_t s_d;
  logic window_layout;

  // Write-zero clears, one per clearable status bit
  logic [twhf_pkg::N_WCLR-1:0] wclr;

  // Set and clear events of each flag
  logic set_in_full;
  logic clr_in_full;
  logic set_out_full;
  logic clr_out_full;
  logic set_host_wm;
  logic clr_host_wm;
  logic set_local_wm;
  logic clr_local_wm;
  logic set_odr_full;
  logic clr_odr_full;
  logic host_first_wins;

  // ---------------------------------------------------------------
  // Status register writes: only written zeros act
  // ---------------------------------------------------------------
  // Ones are ignored, so one flag can be cleared with ones elsewhere
  // without disturbing the others. Plain layout: no clears at all.
  for (genvar g = 0; g < twhf_pkg::N_WCLR; g++) begin : g_wclr
    assign wclr[g] = local_wr_status & window_layout &
      ~local_wr_data[twhf_pkg::WCLR_BIT[g]];
  end

  // ---------------------------------------------------------------
  // Flag events
  // ---------------------------------------------------------------
  always_comb begin
    // Input-full: host fills the last register, local side drains it
    set_in_full = host_wr_last;
    clr_in_full = local_rd_last;

    // Output-full: local side fills, host drains or local writes 0
    set_out_full = local_wr_last;
    clr_out_full = host_rd_last | wclr[twhf_pkg::WCLR_OUT];

    // Host write mode: host claims the first register
    set_host_wm = host_wr_first & ~s_q.local_write_mode_flag;
    clr_host_wm = local_rd_last;

    // Local write mode: a host claim on the same edge takes priority
    host_first_wins = set_host_wm;
    set_local_wm = local_wr_first & ~s_q.host_write_mode_flag &
      ~host_first_wins;
    clr_local_wm = host_rd_last | wclr[twhf_pkg::WCLR_LOCAL];

    // Plain output data register
    set_odr_full = local_wr_odr;
    clr_odr_full = host_rd_odr | wclr[twhf_pkg::WCLR_ODR];
  end

  // ---------------------------------------------------------------
  // Next state; every set wins over a clear in the same cycle
  // ---------------------------------------------------------------
  // Sets come last so that a fill is never lost to a drain that
  // lands on the same edge; the reader then sees the newer data.
  always_comb begin
    s_d = s_q;

    if (clr_in_full) begin
      s_d.window_in_full = 1'b0;
    end
    if (set_in_full) begin
      s_d.window_in_full = 1'b1;
    end

    if (clr_out_full) begin
      s_d.window_out_full = 1'b0;
    end
    if (set_out_full) begin
      s_d.window_out_full = 1'b1;
    end

    if (clr_host_wm) begin
      s_d.host_write_mode_flag = 1'b0;
    end
    if (set_host_wm) begin
      s_d.host_write_mode_flag = 1'b1;
    end

    if (clr_local_wm) begin
      s_d.local_write_mode_flag = 1'b0;
    end
    if (set_local_wm) begin
      s_d.local_write_mode_flag = 1'b1;
    end

    if (clr_odr_full) begin
      s_d.out_full_flag = 1'b0;
    end
    if (set_odr_full) begin
      s_d.out_data_reg = local_wr_data;
      s_d.out_full_flag = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= twhf_pkg::RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Level straight from the flag, so the request lasts as long as it
  assign window_in_full_irq = s_q.window_in_full;
  assign out_data = s_q.out_data_reg;

  twhf_status_mux u_mux (
    .window_enable(window_enable),
    .status_layout_select(status_layout_select),
    .window_in_full(s_q.window_in_full),
    .window_out_full(s_q.window_out_full),
    .host_write_mode_flag(s_q.host_write_mode_flag),
    .local_write_mode_flag(s_q.local_write_mode_flag),
    .out_full_flag(s_q.out_full_flag),
    .shared_low_bits(shared_low_bits),
    .plain_status(plain_status),
    .window_layout(window_layout),
    .status_byte(channel3_window_status)
  );

endmodule : twhf_flags

`default_nettype wire

// *** bench/twhf_host_model.sv ***
// Host processor model: decoded one-cycle I/O cycle pulses
`timescale 1ns/100ps
`default_nettype none
module twhf_host_model (
  // Host I/O cycles, one-cycle pulses
  output logic host_wr_last,
  output logic host_rd_last,
  output logic host_wr_first,
  output logic host_rd_odr
);
  // Written by the bench one cycle at a time, just after an edge
  logic [3:0] req = 4'h0;
  assign {host_wr_last, host_rd_last, host_wr_first, host_rd_odr} = req;
endmodule : twhf_host_model
`default_nettype wire

// *** bench/twhf_flags_properties.sv ***
// Checker of the window handshake flags, bound to the top module
`timescale 1ns/100ps
`default_nettype none
module twhf_flags_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Inputs seen
  input wire logic window_enable,
  input wire logic status_layout_select,
  input wire logic host_wr_last,
  input wire logic host_rd_last,
  input wire logic host_wr_first,
  input wire logic local_wr_last,
  input wire logic local_rd_last,
  input wire logic local_wr_first,
  input wire logic local_wr_odr,
  // Outputs watched
  input wire logic window_in_full_irq,
  input wire logic [7:0] channel3_window_status
);
  wire wl = window_enable || !status_layout_select;
  wire [7:0] s = channel3_window_status;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Flags only visible while the window layout is shown
  sequence s_cause(c);
    c ##1 wl;
  endsequence
  property p_after(c, b);
    s_cause(c) |-> b;
  endproperty
  a_in_set: assert property (host_wr_last |=> window_in_full_irq)
    else $error("input-full not set");
  a_in_clr: assert property (local_rd_last && !host_wr_last |=>
    !window_in_full_irq) else $error("input-full not cleared");
  a_irq_bit: assert property (wl |-> s[7] == window_in_full_irq)
    else $error("irq differs from bit 7");
  a_out_set: assert property (p_after(local_wr_last, s[6]))
    else $error("output-full not set");
  a_out_clr: assert property (p_after(
    host_rd_last && !local_wr_last, !s[6]))
    else $error("output-full not cleared");
  a_host_set: assert property (p_after(
    host_wr_first && wl && !s[4] && !local_rd_last, s[5]))
    else $error("host mode not set");
  a_host_clr: assert property (p_after(
    local_rd_last && !host_wr_first, !s[5]))
    else $error("host mode not cleared");
  a_local_set: assert property (p_after(
    local_wr_first && wl && !s[5] && !host_wr_first, s[4]))
    else $error("local mode not set");
  a_local_clr: assert property (p_after(
    host_rd_last && !local_wr_first, !s[4]))
    else $error("local mode not cleared");
  a_odr_set: assert property (p_after(local_wr_odr, s[0]))
    else $error("data output-full not set");
endmodule : twhf_flags_chk
bind twhf_flags twhf_flags_chk chk (.*);
`default_nettype wire

// *** bench/tb_twhf_flags.sv ***
// Self-checking testbench of the window handshake flags
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("BAD %0t mismatch", $time); end end
module tb_twhf_flags;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic window_enable = 1'b1;
  logic status_layout_select = 1'b1;
  logic [4:0] lp = 5'h00;
  logic [7:0] local_wr_data = 8'h00;
  logic [2:0] shared_low_bits = 3'h5;
  logic [7:0] plain_status = 8'ha5;
  logic [7:0] exp_s = 8'h00;
  wire local_wr_last, local_rd_last, local_wr_first, local_wr_odr;
  wire local_wr_status, window_in_full_irq;
  wire host_wr_last, host_rd_last, host_wr_first, host_rd_odr;
  wire [7:0] out_data, channel3_window_status;
  wire [7:0] s = channel3_window_status;
  int err_count = 0;
  int n_compared = 0;
  assign {local_wr_last, local_rd_last, local_wr_first, local_wr_odr,
    local_wr_status} = lp;
  always #25 core_clk = ~core_clk;
  twhf_host_model host (.*);
  twhf_flags dut (.*);
  task go(input logic [3:0] h, input logic [4:0] l, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    host.req = h;
    lp = l;
    local_wr_data = d;
    @(posedge core_clk);
    #1;
    host.req = 4'h0;
    lp = 5'h00;
  endtask : go
  task t_in;
    go(4'h8, 5'h00, 8'h00);
    `CHK(s[7], 1'b1)
    #150;
    `CHK(window_in_full_irq, 1'b1)
    go(4'h0, 5'h08, 8'h00);
    `CHK(window_in_full_irq, 1'b0)
  endtask : t_in
  task t_out;
    go(4'h0, 5'h10, 8'h00);
    `CHK(s[6], 1'b1)
    go(4'h4, 5'h00, 8'h00);
    `CHK(s[6], 1'b0)
    go(4'h0, 5'h10, 8'h00);
    go(4'h0, 5'h01, 8'hff);
    `CHK(s[6], 1'b1)
    go(4'h0, 5'h01, 8'hbf);
    `CHK(s[6], 1'b0)
  endtask : t_out
  task t_mode;
    go(4'h2, 5'h04, 8'h00);
    `CHK(s[5:4], 2'h2)
    go(4'h0, 5'h08, 8'h00);
    `CHK(s[5], 1'b0)
    go(4'h0, 5'h04, 8'h00);
    go(4'h2, 5'h00, 8'h00);
    `CHK(s[5:4], 2'h1)
    go(4'h0, 5'h01, 8'hef);
    `CHK(s[4], 1'b0)
  endtask : t_mode
  task t_odr;
    go(4'h0, 5'h02, 8'h5a);
    `CHK(s[0], 1'b1)
    `CHK(out_data, 8'h5a)
    go(4'h0, 5'h01, 8'hfe);
    `CHK(s[0], 1'b0)
    for (int i = 0; i < 4; i++) begin
      {window_enable, status_layout_select} = i[1:0];
      exp_s = (i[1] || !i[0]) ? 8'h0a : 8'ha5;
      #1;
      `CHK(s, exp_s)
    end
  endtask : t_odr
  task t_more;
    go(4'h8, 5'h08, 8'h00);
    `CHK(s[7], 1'b1)
    go(4'h0, 5'h04, 8'h00);
    go(4'h4, 5'h00, 8'h00);
    `CHK(s[4], 1'b0)
    go(4'h0, 5'h02, 8'h3c);
    go(4'h1, 5'h00, 8'h00);
    `CHK(s[0], 1'b0)
    `CHK(out_data, 8'h3c)
    go(4'h0, 5'h10, 8'h00);
    window_enable = 1'b0;
    go(4'h0, 5'h01, 8'h00);
    window_enable = 1'b1;
    #1;
    `CHK(s[6], 1'b1)
    rst_b = 1'b0;
    #1;
    `CHK(s, 8'h0a)
    `CHK(out_data, 8'h00)
    @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    go(4'h8, 5'h00, 8'h00);
    `CHK(window_in_full_irq, 1'b1)
  endtask : t_more
  task final_report;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    `CHK(s, 8'h0a)
    t_in;
    t_out;
    t_mode;
    t_odr;
    t_more;
    final_report;
  end
  initial begin
    #20000;
    err_count++;
    final_report;
  end
endmodule : tb_twhf_flags
`default_nettype wire
